// File: tmr2_top.sv
// Timer with capture, auto-reload, clock-out and baud generation behind APB.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_consts.svh"
module tmr2_top
   import tmr2_pkg::*;
#(
   parameter int MCYC = `TMR2_MCYC_CLKS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input,
   input wire logic count_pin_in,
   output logic count_pin_out,
   output logic count_pin_oe,
   output logic irq,
   input wire logic t1_tx_tick,
   input wire logic t1_rx_tick,
   output logic uart_tx_tick,
   output logic uart_rx_tick
);
   // =============================================================
   // State
   // =============================================================
   typedef struct packed {
      logic [7:0] ctrl;
      logic [1:0] mode;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [$clog2(MCYC)-1:0] pre;
      logic pin_prev;
      logic clk_out;
      logic [31:0] rdata;
   } tmr2_st_t;
   tmr2_st_t st_r, st_nxt;

   logic mcyc;
   logic trig_fall;
   logic pin_fall;
   logic roll;
   logic baud_tick;
   tmr2_mode_t mode;

   logic wr;
   logic rd;
   logic hit;
   logic run, exen, ct, down_count_enable, up;
   logic inc;
   logic ovf_ev, udf_ev;
   // Register-write strobes used by the checks to excuse cycles that software owns.
   logic wr_ctrl;
   logic wr_cnt;

   assign mcyc = (st_r.pre == ($clog2(MCYC))'(MCYC - 1));
   assign pin_fall = st_r.pin_prev & ~count_pin_in;

   tmr2_edge tmr2_edge_inst (
      .pclk(pclk),
      .presetn(presetn),
      .sample(mcyc),
      .din(trigger_input),
      .fall(trig_fall)
   );

   tmr2_baud tmr2_baud_inst (
      .pclk(pclk),
      .presetn(presetn),
      .roll(roll),
      .tick(baud_tick)
   );

   // =============================================================
   // Mode decode
   // =============================================================
   always_comb begin
      run = st_r.ctrl[`TMR2_CTRL_RUN];
      exen = st_r.ctrl[`TMR2_CTRL_EXEN];
      ct = st_r.ctrl[`TMR2_CTRL_CT];
      down_count_enable = st_r.mode[`TMR2_MODE_DOWN_COUNT_ENABLE];
      if (!run) begin
         mode = TMR2_OFF;
      end else if (st_r.ctrl[`TMR2_CTRL_RCLK] | st_r.ctrl[`TMR2_CTRL_TX_CLOCK_SELECT]) begin
         mode = TMR2_BAUD;
      end else if (st_r.ctrl[`TMR2_CTRL_CPRL]) begin
         mode = TMR2_CAPT;
      end else if (st_r.mode[`TMR2_MODE_OE]) begin
         mode = TMR2_CLKO;
      end else begin
         mode = TMR2_AUTO;
      end
   end

   // =============================================================
   // Count enable and events
   // =============================================================
   always_comb begin
      // External source counts count-pin falling edges; it is sampled at clock rate.
      if (ct) begin
         inc = pin_fall;
      end else if (mode == TMR2_BAUD || mode == TMR2_CLKO) begin
         // Baud and clock-out use the full clock so the formulas in fclk hold.
         inc = 1'b1;
      end else begin
         inc = mcyc;
      end
      if (mode == TMR2_OFF) begin
         inc = 1'b0;
      end
      // Direction follows the trigger level only in auto-reload with down-count on.
      up = !(mode == TMR2_AUTO && down_count_enable && !trigger_input);
      ovf_ev = inc && up && st_r.cnt == `TMR2_ALL_ONES;
      udf_ev = inc && !up && st_r.cnt == st_r.rld;
      roll = (mode == TMR2_BAUD) && ovf_ev;
   end

   // =============================================================
   // APB
   // =============================================================
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign wr_ctrl = wr && paddr == `TMR2_OFF_CTRL;
   assign wr_cnt = wr && paddr == `TMR2_OFF_CNT;
   assign hit = paddr == `TMR2_OFF_CTRL || paddr == `TMR2_OFF_MODE ||
                paddr == `TMR2_OFF_CNT || paddr == `TMR2_OFF_RLD;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = st_r.rdata;

   // =============================================================
   // Next state
   // =============================================================
   always_comb begin
      st_nxt = st_r;
      st_nxt.pre = mcyc ? '0 : st_r.pre + 1'b1;
      st_nxt.pin_prev = count_pin_in;
      if (rd) begin
         unique case (paddr)
            `TMR2_OFF_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
            `TMR2_OFF_MODE: st_nxt.rdata = {30'h00000000, st_r.mode};
            `TMR2_OFF_CNT: st_nxt.rdata = {16'h0000, st_r.cnt};
            `TMR2_OFF_RLD: st_nxt.rdata = {16'h0000, st_r.rld};
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end
      // Software writes first, so hardware events below win over a clearing write.
      if (wr) begin
         unique case (paddr)
            `TMR2_OFF_CTRL: st_nxt.ctrl = pwdata[7:0];
            `TMR2_OFF_MODE: st_nxt.mode = pwdata[1:0];
            `TMR2_OFF_CNT: st_nxt.cnt = pwdata[15:0];
            `TMR2_OFF_RLD: st_nxt.rld = pwdata[15:0];
            default: ;
         endcase
      end
      if (inc) begin
         st_nxt.cnt = up ? st_r.cnt + 16'h0001 : st_r.cnt - 16'h0001;
      end
      unique case (mode)
         TMR2_CAPT: begin
            if (ovf_ev) st_nxt.ctrl[`TMR2_CTRL_OVF] = 1'b1;
            if (exen && trig_fall) begin
               st_nxt.rld = st_r.cnt;
               st_nxt.ctrl[`TMR2_CTRL_EXF] = 1'b1;
            end
         end
         TMR2_AUTO: begin
            if (ovf_ev) begin
               st_nxt.cnt = st_r.rld;
               st_nxt.ctrl[`TMR2_CTRL_OVF] = 1'b1;
            end
            if (udf_ev) begin
               st_nxt.cnt = `TMR2_ALL_ONES;
               st_nxt.ctrl[`TMR2_CTRL_OVF] = 1'b1;
            end
            if (down_count_enable) begin
               if (ovf_ev || udf_ev) st_nxt.ctrl[`TMR2_CTRL_EXF] = ~st_r.ctrl[`TMR2_CTRL_EXF];
            end else if (exen && trig_fall) begin
               st_nxt.cnt = st_r.rld;
               st_nxt.ctrl[`TMR2_CTRL_EXF] = 1'b1;
            end
         end
         TMR2_CLKO: begin
            // Toggle per rollover gives a 50 % wave, no flag raised.
            if (ovf_ev) begin
               st_nxt.cnt = st_r.rld;
               st_nxt.clk_out = ~st_r.clk_out;
            end
         end
         TMR2_BAUD: begin
            if (ovf_ev) st_nxt.cnt = st_r.rld;
            if (exen && trig_fall) st_nxt.ctrl[`TMR2_CTRL_EXF] = 1'b1;
         end
         TMR2_OFF: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =============================================================
   // Outputs
   // =============================================================
   assign irq = st_r.ctrl[`TMR2_CTRL_OVF] | st_r.ctrl[`TMR2_CTRL_EXF];
   // Pin is driven only while clock-out is configured with internal source.
   assign count_pin_oe = st_r.ctrl[`TMR2_CTRL_RUN] && st_r.mode[`TMR2_MODE_OE] && !st_r.ctrl[`TMR2_CTRL_CT] &&
                         !st_r.ctrl[`TMR2_CTRL_CPRL] && !st_r.ctrl[`TMR2_CTRL_RCLK] && !st_r.ctrl[`TMR2_CTRL_TX_CLOCK_SELECT];
   assign count_pin_out = st_r.clk_out;
   assign uart_tx_tick = st_r.ctrl[`TMR2_CTRL_TX_CLOCK_SELECT] ? baud_tick : t1_tx_tick;
   assign uart_rx_tick = st_r.ctrl[`TMR2_CTRL_RCLK] ? baud_tick : t1_rx_tick;

   // =============================================================
   // Checks
   // =============================================================
   AST_NO_OVF_BAUD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_BAUD && !(wr && paddr == `TMR2_OFF_CTRL)) |=> !$rose(st_r.ctrl[`TMR2_CTRL_OVF]))
      else $error("overflow flag rose in baud mode");
   AST_NO_OVF_CLKO: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CLKO && !wr) |=> !$rose(st_r.ctrl[`TMR2_CTRL_OVF]))
      else $error("overflow flag rose in clock-out mode");
   AST_AUTO_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && ovf_ev && !wr) |=> (st_r.cnt == $past(st_r.rld) && st_r.ctrl[`TMR2_CTRL_OVF]))
      else $error("auto-reload overflow wrong");
   AST_UNDERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && udf_ev && !wr) |=> st_r.cnt == 16'hffff)
      else $error("underflow did not load all ones");
   AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CAPT && exen && trig_fall && !wr) |=> (st_r.rld == $past(st_r.cnt) && st_r.ctrl[`TMR2_CTRL_EXF]))
      else $error("capture failed");
   AST_CAPT_NO_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CAPT && inc && !wr) |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("capture mode count broken");
   AST_EXF_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && down_count_enable && (ovf_ev || udf_ev) && !wr) |=>
      st_r.ctrl[`TMR2_CTRL_EXF] != $past(st_r.ctrl[`TMR2_CTRL_EXF]))
      else $error("event flag did not toggle");
   AST_EDGE_3CYC: assert property (@(posedge pclk) disable iff (!presetn)
      (mcyc && trigger_input) ##1 (!mcyc)[*5] ##1 (mcyc && !trigger_input) |=> trig_fall)
      else $error("trigger edge not seen");
   AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.ctrl[`TMR2_CTRL_OVF] && !wr_ctrl) |=> (st_r.ctrl[`TMR2_CTRL_OVF] && irq))
      else $error("overflow flag or irq dropped without a clear");
   AST_BAUD_TX: assert property (@(posedge pclk) disable iff (!presetn)
      !st_r.ctrl[`TMR2_CTRL_TX_CLOCK_SELECT] |-> uart_tx_tick == t1_tx_tick)
      else $error("tx clock select wrong");

   // =============================================================
   // Checks: counting and reload
   // =============================================================
   AST_CAPT_OVF: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CAPT && ovf_ev) |=> st_r.ctrl[`TMR2_CTRL_OVF])
      else $error("capture mode overflow did not set the flag");
   AST_TRIG_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && !down_count_enable && exen && trig_fall && !wr) |=> (st_r.cnt == $past(st_r.rld) && st_r.ctrl[`TMR2_CTRL_EXF]))
      else $error("trigger edge did not reload");
   AST_UP_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && down_count_enable && trigger_input && ovf_ev && !wr) |=> (st_r.cnt == $past(st_r.rld) && st_r.ctrl[`TMR2_CTRL_OVF]))
      else $error("up/down overflow did not reload");
   AST_DOWN_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && down_count_enable && !trigger_input && inc && !udf_ev && !wr_cnt) |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
      else $error("down count step wrong");
   AST_UP_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_AUTO && !down_count_enable && inc && !ovf_ev && !(exen && trig_fall) && !wr_cnt) |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("auto-reload did not count up");
   // A stopped timer must hold its count, or software reads taken with the run bit clear mislead.
   AST_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
      (!run && !wr_cnt) |=> $stable(st_r.cnt))
      else $error("count moved while stopped");
   AST_EXT_EDGE_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CAPT && ct && !pin_fall && !wr_cnt) |=> $stable(st_r.cnt))
      else $error("external source counted without a pin edge");

   // =============================================================
   // Checks: baud generation
   // =============================================================
   AST_BAUD_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_BAUD && ovf_ev && !wr) |=> st_r.cnt == $past(st_r.rld))
      else $error("baud rollover did not reload");
   // The trigger edge must not disturb this step, which also shows that it causes no reload.
   AST_BAUD_FULL_RATE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_BAUD && !ct && !ovf_ev && !wr_cnt) |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("baud mode did not count every clock");
   AST_BAUD_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_BAUD && exen && trig_fall) |=> st_r.ctrl[`TMR2_CTRL_EXF])
      else $error("baud mode trigger edge did not set the event flag");
   AST_TICK_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      baud_tick |=> !baud_tick)
      else $error("baud tick longer than one cycle");
   AST_UART_RX: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.ctrl[`TMR2_CTRL_RCLK] |-> uart_rx_tick == baud_tick)
      else $error("rx clock select wrong");

   // =============================================================
   // Checks: clock-out
   // =============================================================
   AST_CLKO_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CLKO && ovf_ev && !wr) |=> (st_r.clk_out != $past(st_r.clk_out) && st_r.cnt == $past(st_r.rld)))
      else $error("clock-out rollover did not toggle and reload");
   AST_CLKO_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !(mode == TMR2_CLKO && ovf_ev) |=> $stable(st_r.clk_out))
      else $error("clock-out level changed without a rollover");
   AST_CLKO_OE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CLKO && !ct) |-> count_pin_oe)
      else $error("count pin not driven in clock-out mode");
   AST_NO_OE: assert property (@(posedge pclk) disable iff (!presetn)
      (mode != TMR2_CLKO) |-> !count_pin_oe)
      else $error("count pin driven outside clock-out mode");

   // =============================================================
   // Checks: event flag
   // =============================================================
   AST_CAPT_EXF: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == TMR2_CAPT && exen && trig_fall) |=> st_r.ctrl[`TMR2_CTRL_EXF])
      else $error("capture edge did not set the event flag");
   AST_EDGE_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn)
      trig_fall |-> ($past(mcyc) && !$past(trigger_input)))
      else $error("trigger edge reported without a low sample");
   // Up/down mode is left out because the event flag toggles there as a seventeenth count bit.
   AST_EXF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.ctrl[`TMR2_CTRL_EXF] && !wr_ctrl && !(mode == TMR2_AUTO && down_count_enable)) |=> st_r.ctrl[`TMR2_CTRL_EXF])
      else $error("event flag dropped without a clear");
   AST_EXF_RISE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_r.ctrl[`TMR2_CTRL_EXF]) |-> ($past(trig_fall) || $past(wr_ctrl) || $past(ovf_ev) || $past(udf_ev)))
      else $error("event flag rose without a cause");
   COV_CAPT: cover property (@(posedge pclk) mode == TMR2_CAPT && exen && trig_fall);
   COV_UDF: cover property (@(posedge pclk) mode == TMR2_AUTO && udf_ev);
   COV_CLKO: cover property (@(posedge pclk) mode == TMR2_CLKO && ovf_ev);
   COV_BAUD: cover property (@(posedge pclk) baud_tick);
endmodule // tmr2_top
`default_nettype wire

// File: tmr2_consts.svh
// Constants for the capture/reload/baud timer block.
// =============================================================
// How it works
// - Capture mode, trigger disabled: 16-bit counter, overflow sets overflow flag.
// - Capture mode, trigger enabled: trigger falling edge copies count into reload bytes.
// - Trigger edge sets event flag except in clock-out and up/down modes; both flags share one interrupt request.
// - Capture mode never reloads; counting continues through a capture.
// - Captures are unprotected; every trigger edge overwrites reload bytes.
// - Down-count enable resets to 0; when set, trigger level picks direction.
// - Auto-reload up, trigger disabled: overflow at ffff sets flag and reloads.
// - Auto-reload up, trigger enabled: overflow or trigger edge reloads; edge sets event flag.
// - Edge detect: sampled high, then low, flag set in third machine cycle.
// - Up/down with trigger high counts up, overflows at ffff, sets flag, reloads.
// - Up/down with trigger low counts down; at reload value sets flag, loads ffff.
// - In up/down mode event flag toggles on every overflow and underflow.
// - Clock-out: count source cleared, output enable and run set drive square wave.
// - Clock-out frequency is fclk over twice (65536 minus reload value).
// - Clock-out rollovers request no interrupt.
// - Tx and rx clock selects independently pick this timer or the other.
// - Baud mode: rollover reloads counter; baud tick is overflow rate over 16.
// - Baud mode with internal source counts every clock, not machine cycle.
// - Baud mode rollover sets no overflow flag and requests no interrupt.
// - Baud mode trigger edge sets event flag but causes no reload.
// - Mode priority: clock selects, then capture, then clock-out, else auto-reload.
// - Overflow flag never set in baud or clock-out mode.
// - Count source select 1 counts count pin falling edges, else machine cycles, or every clock in baud and clock-out mode.
`ifndef TMR2_CONSTS_SVH
`define TMR2_CONSTS_SVH
`define TMR2_OFF_CTRL 12'h000
`define TMR2_OFF_MODE 12'h004
`define TMR2_OFF_CNT 12'h008
`define TMR2_OFF_RLD 12'h00c
`define TMR2_CTRL_OVF 7
`define TMR2_CTRL_EXF 6
`define TMR2_CTRL_RCLK 5
`define TMR2_CTRL_TX_CLOCK_SELECT 4
`define TMR2_CTRL_EXEN 3
`define TMR2_CTRL_RUN 2
`define TMR2_CTRL_CT 1
`define TMR2_CTRL_CPRL 0
`define TMR2_MODE_OE 1
`define TMR2_MODE_DOWN_COUNT_ENABLE 0
`define TMR2_MCYC_CLKS 6
`define TMR2_BAUD_DIV 16
`define TMR2_ALL_ONES 16'hffff
`endif

// File: tmr2_pkg.sv
// Types shared by the capture/reload/baud timer block.
package tmr2_pkg;
   typedef enum logic [2:0] {TMR2_OFF, TMR2_AUTO, TMR2_CAPT, TMR2_CLKO, TMR2_BAUD} tmr2_mode_t;
endpackage

// File: tmr2_edge.sv
// Falling-edge detector sampled once per machine cycle.
`timescale 1ns/1ps
`default_nettype none
module tmr2_edge
   import tmr2_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample,
   input wire logic din,
   output logic fall
);
   typedef struct packed {
      logic prev;
      logic fall;
   } tmr2_edge_st_t;
   tmr2_edge_st_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.fall = 1'b0;
      if (sample) begin
         // A high sample then a low sample gives the pulse on the next clock.
         st_nxt.fall = st_r.prev & ~din;
         st_nxt.prev = din;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign fall = st_r.fall;
endmodule // tmr2_edge
`default_nettype wire

// File: tmr2_baud.sv
// Divide-by-16 of timer rollovers into the UART baud ticks.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_consts.svh"
module tmr2_baud
   import tmr2_pkg::*;
#(
   parameter int DIV = `TMR2_BAUD_DIV
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic roll,
   output logic tick
);
   typedef struct packed {
      logic [$clog2(DIV)-1:0] cnt;
      logic tick;
   } tmr2_baud_st_t;
   tmr2_baud_st_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (roll) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
         st_nxt.tick = (st_r.cnt == ($clog2(DIV))'(DIV - 1));
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = st_r.tick;
endmodule // tmr2_baud
`default_nettype wire

// File: tmr2_far.sv
// Far-side model: trigger and count pins, other timer's baud ticks, UART tick sink.
`timescale 1ns/1ps
`default_nettype none
module tmr2_far
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic count_pin_out,
   input wire logic count_pin_oe,
   input wire logic uart_tx_tick,
   input wire logic uart_rx_tick,
   output logic trigger_input,
   output logic count_pin_in,
   output logic t1_tx_tick,
   output logic t1_rx_tick
);
   logic trig_lvl = 1'b1;
   logic pin_lvl = 1'b1;
   int cyc;
   int ticks_seen;
   assign trigger_input = trig_lvl;
   // The wire carries the device's level whenever it drives, else ours.
   assign count_pin_in = count_pin_oe ? count_pin_out : pin_lvl;
   assign t1_tx_tick = (cyc % 10) == 9;
   assign t1_rx_tick = (cyc % 12) == 11;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc <= 0;
         ticks_seen <= 0;
      end else begin
         cyc <= cyc + 1;
         ticks_seen <= ticks_seen + int'(uart_tx_tick) + int'(uart_rx_tick);
      end
   end
endmodule // tmr2_far
`default_nettype wire

// File: tmr2_tb_top.sv
// Self-checking testbench for the capture/reload/baud timer.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_consts.svh"
module tmr2_tb_top;
   import tmr2_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic trigger_input, count_pin_in, count_pin_out, count_pin_oe;
   logic t1_tx_tick, t1_rx_tick, uart_tx_tick, uart_rx_tick, err;
   int mismatches, n_tests, g;
   tmr2_top tmr2_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_input(trigger_input), .count_pin_in(count_pin_in),
      .count_pin_out(count_pin_out), .count_pin_oe(count_pin_oe), .irq(irq),
      .t1_tx_tick(t1_tx_tick), .t1_rx_tick(t1_rx_tick), .uart_tx_tick(uart_tx_tick),
      .uart_rx_tick(uart_rx_tick));
   tmr2_far tmr2_far_inst (.pclk(pclk), .presetn(presetn), .count_pin_out(count_pin_out),
      .count_pin_oe(count_pin_oe), .uart_tx_tick(uart_tx_tick), .uart_rx_tick(uart_rx_tick),
      .trigger_input(trigger_input), .count_pin_in(count_pin_in), .t1_tx_tick(t1_tx_tick),
      .t1_rx_tick(t1_rx_tick));
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   // ==========================================================
   // Access and compare tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait ends on the first clock edge that sees pready high.
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(what, e, q);
   endtask
   task automatic trig(input logic v, input int wait_cyc);
      tmr2_far_inst.trig_lvl <= v;
      repeat (wait_cyc) @(posedge pclk);
   endtask
   task automatic pin_pulse();
      tmr2_far_inst.pin_lvl <= 1'b0;
      repeat (3) @(posedge pclk);
      tmr2_far_inst.pin_lvl <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   function automatic logic sel(input int s);
      return s == 0 ? count_pin_out : (s == 1 ? uart_tx_tick : uart_rx_tick);
   endfunction
   // Cycles between two rising edges of the chosen output.
   task automatic gap(input int s);
      logic p;
      int n;
      repeat (2) begin
         n = 0;
         p = sel(s);
         @(posedge pclk);
         while (!(sel(s) === 1'b1 && p === 1'b0) && n < 300) begin
            p = sel(s);
            @(posedge pclk);
            n++;
         end
      end
      g = n + 1;
   endtask
   task automatic wirq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
      chk("irq_raised", 32'h1, {31'h0, irq});
   endtask
   task automatic test_done();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      test_done();
   end
   // ==========================================================
   // Tests
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
      mismatches = 0; n_tests = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl_rst", `TMR2_OFF_CTRL, 32'h0);
      rd("mode_rst", `TMR2_OFF_MODE, 32'h0);
      rd("cnt_rst", `TMR2_OFF_CNT, 32'h0);
      rd("rld_rst", `TMR2_OFF_RLD, 32'h0);
      wr(12'h010, 32'hff);
      chk("slverr", 32'h1, {31'h0, err});
      chk("pready", 32'h1, {31'h0, pready});
      rd("unmapped", 12'h010, 32'h0);
      rd("ctrl_kept", `TMR2_OFF_CTRL, 32'h0);
      $display("test reset done");
      wr(`TMR2_OFF_CNT, 32'hfffe);
      wr(`TMR2_OFF_RLD, 32'hfff0);
      wr(`TMR2_OFF_CTRL, 32'h04);
      wirq();
      rd("auto_flags", `TMR2_OFF_CTRL, 32'h84);
      wr(`TMR2_OFF_CTRL, 32'h0);
      apb(1'b0, `TMR2_OFF_CNT, 32'h0);
      chk("auto_reload", 32'h1, {31'h0, q >= 32'hfff0 && q <= 32'hfff3});
      @(negedge pclk);
      chk("irq_clear", 32'h0, {31'h0, irq});
      wr(`TMR2_OFF_CNT, 32'h0100);
      wr(`TMR2_OFF_CTRL, 32'h0c);
      trig(1'b0, 24);
      rd("trig_flags", `TMR2_OFF_CTRL, 32'h4c);
      wr(`TMR2_OFF_CTRL, 32'h0);
      apb(1'b0, `TMR2_OFF_CNT, 32'h0);
      chk("trig_reload", 32'h1, {31'h0, q >= 32'hfff0 && q <= 32'hfff5});
      trig(1'b1, 12);
      $display("test auto-reload done");
      wr(`TMR2_OFF_CNT, 32'h1234);
      wr(`TMR2_OFF_CTRL, 32'h0f);
      trig(1'b0, 24);
      rd("capt1", `TMR2_OFF_RLD, 32'h1234);
      rd("capt_flag", `TMR2_OFF_CTRL, 32'h4f);
      chk("capt_irq", 32'h1, {31'h0, irq});
      repeat (3) pin_pulse();
      trig(1'b1, 12);
      trig(1'b0, 24);
      rd("capt2", `TMR2_OFF_RLD, 32'h1237);
      rd("capt_cnt", `TMR2_OFF_CNT, 32'h1237);
      wr(`TMR2_OFF_CTRL, 32'h0);
      trig(1'b1, 12);
      $display("test capture done");
      wr(`TMR2_OFF_MODE, 32'h1);
      trig(1'b0, 12);
      wr(`TMR2_OFF_CNT, 32'h0003);
      wr(`TMR2_OFF_RLD, 32'h0001);
      wr(`TMR2_OFF_CTRL, 32'h04);
      wirq();
      rd("down_flags", `TMR2_OFF_CTRL, 32'hc4);
      wr(`TMR2_OFF_CTRL, 32'h0);
      apb(1'b0, `TMR2_OFF_CNT, 32'h0);
      chk("down_load", 32'h1, {31'h0, q >= 32'hfffd && q <= 32'hffff});
      trig(1'b1, 12);
      wr(`TMR2_OFF_CNT, 32'hfffe);
      wr(`TMR2_OFF_RLD, 32'h0010);
      wr(`TMR2_OFF_CTRL, 32'h04);
      wirq();
      rd("up_flags", `TMR2_OFF_CTRL, 32'hc4);
      wr(`TMR2_OFF_CTRL, 32'h0);
      apb(1'b0, `TMR2_OFF_CNT, 32'h0);
      chk("up_reload", 32'h1, {31'h0, q >= 32'h0010 && q <= 32'h0012});
      wr(`TMR2_OFF_MODE, 32'h0);
      $display("test up/down done");
      wr(`TMR2_OFF_RLD, 32'hfffc);
      wr(`TMR2_OFF_CNT, 32'hfffc);
      wr(`TMR2_OFF_MODE, 32'h2);
      wr(`TMR2_OFF_CTRL, 32'h04);
      gap(0);
      chk("clko_period", 32'd8, g);
      chk("clko_oe", 32'h1, {31'h0, count_pin_oe});
      rd("clko_flags", `TMR2_OFF_CTRL, 32'h04);
      chk("clko_irq", 32'h0, {31'h0, irq});
      wr(`TMR2_OFF_CTRL, 32'h0);
      wr(`TMR2_OFF_MODE, 32'h0);
      $display("test clock-out done");
      wr(`TMR2_OFF_RLD, 32'hfffe);
      wr(`TMR2_OFF_CTRL, 32'h1c);
      gap(1);
      chk("baud_tx", 32'd32, g);
      gap(2);
      chk("baud_rx", 32'd12, g);
      trig(1'b0, 24);
      rd("baud_flags", `TMR2_OFF_CTRL, 32'h5c);
      wr(`TMR2_OFF_CTRL, 32'h0);
      rd("baud_rld", `TMR2_OFF_RLD, 32'hfffe);
      trig(1'b1, 12);
      $display("test baud done");
      test_done();
   end
endmodule // tmr2_tb_top
`default_nettype wire
